// file: mch_defs.svh
// Constants for the module-to-carrier power handshake block.
`ifndef MCH_DEFS_SVH
`define MCH_DEFS_SVH

// Register byte offsets.
`define MCH_OFF_CTRL      12'h000
`define MCH_OFF_STATUS    12'h004
`define MCH_OFF_DUTY      12'h008
`define MCH_OFF_DEBOUNCE  12'h00C
`define MCH_OFF_SETTLE    12'h010
`define MCH_OFF_EVENTS    12'h014

// Control register fields.
`define MCH_CTRL_LID_SLEEP   0
`define MCH_CTRL_STBY_REQ    1
`define MCH_CTRL_PANEL       2
`define MCH_CTRL_BKLT        3
`define MCH_CTRL_RESET       8'h01

// Event register fields.
`define MCH_EV_WAKE   0
`define MCH_EV_LID    1
`define MCH_EV_SLEEP  2

// Filtered input vector positions.
`define MCH_IN_FAULT   0
`define MCH_IN_READY   1
`define MCH_IN_CRST    2
`define MCH_IN_STRAP   3
`define MCH_IN_LID     4
`define MCH_IN_DOZE    5
`define MCH_IN_BATT    6
`define MCH_IN_CHRG    7
`define MCH_IN_WAKE    8
`define MCH_IN_COUNT   9

// Debounced inputs form the upper group, others pass after the synchroniser.
`define MCH_DEB_FIRST  4

`define MCH_DUTY_RESET  8'h80
`define MCH_RESP_OKAY   2'b00
`define MCH_RESP_SLVERR 2'b10

// Timing in microseconds, the clock rate in MHz and the PWM divider in clock cycles.
`define MCH_CLK_MHZ      200
`define MCH_DEBOUNCE_US  10000
`define MCH_SETTLE_US    1000
`define MCH_PWM_DIV      16'h0030

`endif

// file: mch_pkg.sv
// Types shared by the power handshake block.
package mch_pkg;

    typedef enum logic [2:0] {
        MCH_ST_OFF    = 3'b000,
        MCH_ST_SETTLE = 3'b001,
        MCH_ST_WAIT   = 3'b010,
        MCH_ST_RUN    = 3'b011,
        MCH_ST_STBY   = 3'b100
    } mch_state_t;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        lvl;
        logic [31:0] cnt;
    } mch_filt_t;

    typedef struct packed {
        logic [15:0] div;
        logic [7:0]  ph;
        logic        out;
    } mch_pwm_t;

    typedef struct packed {
        mch_state_t  st;
        logic [31:0] cnt;
        logic        dpe;
        logic        rst_out_n;
        logic        boot;
        logic        sd_boot;
        logic        sup_en;
        logic        stby_n;
        logic        pnl;
        logic        bklt;
        logic [7:0]  ctrl;
        logic [7:0]  duty;
        logic [31:0] deb;
        logic [31:0] settle;
        logic [2:0]  ev;
        logic        lid_d;
        logic        doze_d;
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic        w_have;
        logic [11:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } mch_top_t;

endpackage

// file: mch_filter.sv
// Two-stage synchroniser with a stability filter for one carrier input.
`timescale 1ns/1ps
`default_nettype none
module mch_filter
    import mch_pkg::*;
#(
    parameter logic INIT = 1'b1
)
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Raw level and required stable cycles.
    input  wire logic        din,
    input  wire logic [31:0] limit,
    // Accepted level.
    output logic             dout
);

    mch_filt_t q;
    mch_filt_t d;

    // The first stage feeds only the second; filtering looks at the second.
    always_comb
    begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        if (q.s2 == q.lvl)
        begin
            d.cnt = 32'h0000_0000;
        end
        else if (q.cnt >= limit)
        begin
            d.lvl = q.s2;
            d.cnt = 32'h0000_0000;
        end
        else
        begin
            d.cnt = q.cnt + 32'h0000_0001;
        end
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '{s1: INIT, s2: INIT, lvl: INIT, cnt: 32'h0000_0000};
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.lvl;

endmodule
`default_nettype wire

// file: mch_pwm.sv
// Backlight brightness pulse generator with a free-running prescaler and an output enable.
`timescale 1ns/1ps
`default_nettype none
`include "mch_defs.svh"
module mch_pwm
    import mch_pkg::*;
#(
    parameter logic [15:0] DIV = `MCH_PWM_DIV
)
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Enable and duty, duty/256 high time.
    input  wire logic       en,
    input  wire logic [7:0] duty,
    // Pulse output.
    output logic            pulse
);

    mch_pwm_t q;
    mch_pwm_t d;

    // The divider gives a one-cycle tick; the phase counter steps on it.
    always_comb
    begin
        d = q;
        if (q.div >= DIV)
        begin
            d.div = 16'h0000;
            d.ph  = q.ph + 8'h01;
        end
        else
        begin
            d.div = q.div + 16'h0001;
        end
        d.out = en && (q.ph < duty);
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '{div: 16'h0000, ph: 8'h00, out: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign pulse = q.out;

endmodule
`default_nettype wire

// file: mch_top.sv
// Module-side power handshake sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "mch_defs.svh"
module mch_top
    import mch_pkg::*;
#(
    parameter logic [31:0] DEBOUNCE_CYCLES = `MCH_DEBOUNCE_US * `MCH_CLK_MHZ,
    parameter logic [31:0] SETTLE_CYCLES   = `MCH_SETTLE_US * `MCH_CLK_MHZ
)
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Supply and carrier handshake inputs.
    input  wire logic        input_supply_fault_n,
    input  wire logic        module_power_ready,
    input  wire logic        carrier_reset_n,
    input  wire logic        sd_boot_strap_n,
    // Carrier status inputs, active low.
    input  wire logic        lid_closed_n,
    input  wire logic        doze_request_n,
    input  wire logic        battery_depleted_n,
    input  wire logic        charger_input_present_n,
    input  wire logic        sideband_wake_n,
    // Power sequencing outputs.
    output logic             module_supplies_enable,
    output logic             downstream_power_enable,
    output logic             carrier_reset_out_n,
    output logic             boot_release,
    output logic             boot_from_sd,
    output logic             standby_indicator_n,
    // Panel controls.
    output logic             panel0_supply_on,
    output logic             panel0_backlight_on,
    output logic             panel0_brightness_pulse
);

    mch_top_t q;
    mch_top_t d;
    logic [`MCH_IN_COUNT-1:0] raw;
    logic [`MCH_IN_COUNT-1:0] flt;
    logic                     sleep_cause;
    logic                     wr_hit;
    logic                     rd_hit;
    logic [31:0]              rd_val;
    logic [31:0]              status;

    assign raw = {sideband_wake_n, charger_input_present_n, battery_depleted_n,
                  doze_request_n, lid_closed_n, sd_boot_strap_n, carrier_reset_n,
                  module_power_ready, input_supply_fault_n};

    // Handshake inputs only need the synchroniser; status inputs are also debounced.
    // Fault and ready start low so no supply is enabled before the pins are seen.
    // active-low status levels debounced
    genvar gi;
    generate
        for (gi = 0; gi < `MCH_IN_COUNT; gi = gi + 1)
        begin : g_in
            mch_filter #(
                .INIT ((gi == `MCH_IN_READY || gi == `MCH_IN_FAULT) ? 1'b0 : 1'b1)
            ) u_filt (
                .aclk    (aclk),
                .aresetn (aresetn),
                .din     (raw[gi]),
                .limit   ((gi >= `MCH_DEB_FIRST) ? q.deb : 32'h0000_0000),
                .dout    (flt[gi])
            );
        end
    endgenerate

    // Byte-lane merge for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Reasons to enter standby.
    always_comb
    begin
        sleep_cause = !flt[`MCH_IN_DOZE]
                    || (!flt[`MCH_IN_LID] && q.ctrl[`MCH_CTRL_LID_SLEEP])
                    || q.ctrl[`MCH_CTRL_STBY_REQ];
    end

    // Status word: state, handshake levels and debounced carrier status.
    always_comb
    begin
        status        = 32'h0000_0000;
        status[2:0]   = q.st;
        status[3]     = q.sd_boot;
        status[4]     = !flt[`MCH_IN_FAULT];
        status[5]     = flt[`MCH_IN_READY];
        status[6]     = !flt[`MCH_IN_CRST];
        status[7]     = !flt[`MCH_IN_LID];
        status[8]     = !flt[`MCH_IN_DOZE];
        status[9]     = !flt[`MCH_IN_BATT];
        status[10]    = !flt[`MCH_IN_CHRG];
        status[11]    = !flt[`MCH_IN_WAKE];
    end

    // Read decode; unmapped offsets answer with an error and zero data.
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `MCH_OFF_CTRL:     rd_val = {24'h00_0000, q.ctrl};
            `MCH_OFF_STATUS:   rd_val = status;
            `MCH_OFF_DUTY:     rd_val = {24'h00_0000, q.duty};
            `MCH_OFF_DEBOUNCE: rd_val = q.deb;
            `MCH_OFF_SETTLE:   rd_val = q.settle;
            `MCH_OFF_EVENTS:   rd_val = {29'h0000_0000, q.ev};
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next-state logic for sequencer, register file and bus channels.
    always_comb
    begin
        d = q;
        wr_hit = 1'b0;

        // Write channels are taken in either order and held until both are in.
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end

        // Edge detection on the lid and doze inputs; software clears events by writing ones.
        d.lid_d  = flt[`MCH_IN_LID];
        d.doze_d = flt[`MCH_IN_DOZE];
        if (q.aw_have && q.w_have && !q.bvalid && q.aw_addr == `MCH_OFF_EVENTS)
        begin
            d.ev = q.ev & ~q.wdata[2:0];
        end

        // Commit a write once both halves are held.
        if (q.aw_have && q.w_have && !q.bvalid)
        begin
            wr_hit = 1'b1;
            case (q.aw_addr)
                `MCH_OFF_CTRL:     d.ctrl   = 8'(merge({24'h00_0000, q.ctrl}, q.wdata, q.wstrb));
                `MCH_OFF_DUTY:     d.duty   = 8'(merge({24'h00_0000, q.duty}, q.wdata, q.wstrb));
                `MCH_OFF_DEBOUNCE: d.deb    = merge(q.deb, q.wdata, q.wstrb);
                `MCH_OFF_SETTLE:   d.settle = merge(q.settle, q.wdata, q.wstrb);
                `MCH_OFF_EVENTS:   wr_hit = 1'b1;
                `MCH_OFF_STATUS:   wr_hit = 1'b1;
                default:           wr_hit = 1'b0;
            endcase
            d.bresp   = wr_hit ? `MCH_RESP_OKAY : `MCH_RESP_SLVERR;
            d.bvalid  = 1'b1;
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;

        // Set wins over a clear in the same cycle.
        // wake assertion is an event
        if (!flt[`MCH_IN_WAKE])
        begin
            d.ev[`MCH_EV_WAKE] = 1'b1;
        end
        if (q.lid_d && !flt[`MCH_IN_LID])
        begin
            d.ev[`MCH_EV_LID] = 1'b1;
        end
        if (q.doze_d && !flt[`MCH_IN_DOZE])
        begin
            d.ev[`MCH_EV_SLEEP] = 1'b1;
        end

        // Read channel: one outstanding read, data one cycle after the address.
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata  = rd_val;
            d.rresp  = rd_hit ? `MCH_RESP_OKAY : `MCH_RESP_SLVERR;
        end
        d.arready = !d.rvalid;

        // Power sequencer.
        case (q.st)
            MCH_ST_OFF:
            begin
                if (flt[`MCH_IN_FAULT] && flt[`MCH_IN_READY])
                begin
                    d.st  = MCH_ST_SETTLE;
                    d.cnt = 32'h0000_0000;
                end
            end
            MCH_ST_SETTLE:
            begin
                if (q.cnt >= q.settle)
                begin
                    d.st = MCH_ST_WAIT;
                end
                else
                begin
                    d.cnt = q.cnt + 32'h0000_0001;
                end
            end
            MCH_ST_WAIT:
            begin
                if (flt[`MCH_IN_CRST])
                begin
                    d.st = MCH_ST_RUN;
                    d.sd_boot = !flt[`MCH_IN_STRAP];
                end
            end
            MCH_ST_RUN:
            begin
                if (!flt[`MCH_IN_CRST])
                begin
                    d.st = MCH_ST_WAIT;
                end
                else if (sleep_cause)
                begin
                    d.st = MCH_ST_STBY;
                end
            end
            MCH_ST_STBY:
            begin
                // Wake or loss of every sleep cause returns to running.
                if (!flt[`MCH_IN_CRST])
                begin
                    d.st = MCH_ST_WAIT;
                end
                else if (!flt[`MCH_IN_WAKE] || !sleep_cause)
                begin
                    d.st = MCH_ST_RUN;
                end
            end
            default:
            begin
                d.st = MCH_ST_OFF;
            end
        endcase

        if (!flt[`MCH_IN_FAULT] || !flt[`MCH_IN_READY])
        begin
            d.st = MCH_ST_OFF;
        end

        // Outputs except sup_en follow the next state so they are registered with it.
        // supplies off while fault held
        d.sup_en    = flt[`MCH_IN_FAULT];
        d.dpe       = (d.st != MCH_ST_OFF);
        d.rst_out_n = (d.st != MCH_ST_OFF) && (d.st != MCH_ST_SETTLE);
        d.boot      = (d.st == MCH_ST_RUN) || (d.st == MCH_ST_STBY);
        d.stby_n    = (d.st != MCH_ST_STBY);
        d.pnl       = (d.st == MCH_ST_RUN) && q.ctrl[`MCH_CTRL_PANEL];
        d.bklt      = (d.st == MCH_ST_RUN) && q.ctrl[`MCH_CTRL_PANEL] && q.ctrl[`MCH_CTRL_BKLT];
    end

    // Single state register; reset puts the sequencer in off and loads the register defaults.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.st        <= MCH_ST_OFF;
            q.stby_n    <= 1'b1;
            q.ctrl      <= `MCH_CTRL_RESET;
            q.duty      <= `MCH_DUTY_RESET;
            q.deb       <= DEBOUNCE_CYCLES;
            q.settle    <= SETTLE_CYCLES;
            q.lid_d     <= 1'b1;
            q.doze_d    <= 1'b1;
            q.awready   <= 1'b1;
            q.wready    <= 1'b1;
            q.arready   <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Brightness pulse is gated by the backlight; the divider and phase counter run freely.
    mch_pwm u_pwm (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (q.bklt),
        .duty    (q.duty),
        .pulse   (panel0_brightness_pulse)
    );

    assign s_axi_awready           = q.awready;
    assign s_axi_wready            = q.wready;
    assign s_axi_bvalid            = q.bvalid;
    assign s_axi_bresp             = q.bresp;
    assign s_axi_arready           = q.arready;
    assign s_axi_rvalid            = q.rvalid;
    assign s_axi_rdata             = q.rdata;
    assign s_axi_rresp             = q.rresp;
    assign module_supplies_enable  = q.sup_en;
    assign downstream_power_enable = q.dpe;
    assign carrier_reset_out_n     = q.rst_out_n;
    assign boot_release            = q.boot;
    assign boot_from_sd            = q.sd_boot;
    assign standby_indicator_n     = q.stby_n;
    assign panel0_supply_on        = q.pnl;
    assign panel0_backlight_on     = q.bklt;

endmodule
`default_nettype wire

// file: mch_monitor.sv
// Port-level checks on the power handshake block.
`timescale 1ns/1ps
`default_nettype none
module mch_monitor
    import mch_pkg::*;
#(
    parameter logic [31:0] SETTLE_CYCLES = 32'h0000_0004
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Handshake inputs.
    input wire logic input_supply_fault_n,
    input wire logic module_power_ready,
    input wire logic carrier_reset_n,
    // Sequencer and panel outputs.
    input wire logic module_supplies_enable,
    input wire logic downstream_power_enable,
    input wire logic carrier_reset_out_n,
    input wire logic boot_release,
    input wire logic standby_indicator_n,
    input wire logic panel0_supply_on,
    input wire logic panel0_backlight_on,
    input wire logic panel0_brightness_pulse
);
    logic [31:0] settle_r;

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Counts enabled cycles while the carrier is still held in reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !downstream_power_enable || carrier_reset_out_n)
            settle_r <= 32'h0000_0000;
        else
            settle_r <= settle_r + 32'h0000_0001;
    end

    chk_enable_ready: assert property (
        $rose(downstream_power_enable) |->
        $past(module_power_ready, 4) && $past(input_supply_fault_n, 4))
        else $error("power enable rose before supplies were ready");
    chk_fault_off: assert property (
        !input_supply_fault_n [*6] |-> !module_supplies_enable && !downstream_power_enable)
        else $error("supplies enabled during input fault");
    chk_boot_after_rst: assert property (
        $rose(boot_release) |-> $past(carrier_reset_n, 4) && carrier_reset_out_n)
        else $error("boot released while carrier reset held");
    chk_boot_power: assert property (
        boot_release |-> downstream_power_enable)
        else $error("boot released without power");
    chk_stby_level: assert property (
        !standby_indicator_n |-> boot_release && downstream_power_enable)
        else $error("standby shown outside a powered state");
    chk_settle_time: assert property (
        $rose(carrier_reset_out_n) |-> settle_r == SETTLE_CYCLES + 32'h0000_0001)
        else $error("carrier reset released after wrong settle time");
    chk_bklt_panel: assert property (
        panel0_backlight_on |-> panel0_supply_on)
        else $error("backlight on without panel supply");
    chk_pulse_gated: assert property (
        !panel0_backlight_on [*3] |-> !panel0_brightness_pulse)
        else $error("brightness pulse while backlight off");
    chk_sync_depth: assert property (
        $rose(module_supplies_enable) |->
        $past(input_supply_fault_n, 4) && !$past(input_supply_fault_n, 5))
        else $error("fault input not passed through two sync stages");
endmodule

bind mch_top mch_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_mon (.*);
`default_nettype wire

// file: mch_carrier_model.sv
// Carrier-side model that brings its rails up and then releases module reset.
`timescale 1ns/1ps
`default_nettype none
module mch_carrier_model
    import mch_pkg::*;
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Module outputs that gate carrier power.
    input  wire logic       downstream_power_enable,
    input  wire logic       carrier_reset_out_n,
    // Bench controls: forced reset and rail delay.
    input  wire logic       hold_reset,
    input  wire logic [7:0] delay,
    // Open-drain reset towards the module.
    output logic            carrier_reset_n
);
    logic [7:0] up_r;

    // Main rails start only once the module enables them.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !downstream_power_enable)
            up_r <= 8'h00;
        else if (up_r != 8'hff)
            up_r <= up_r + 8'h01;
    end

    // Reset released last; a released line floats to the pull-up.
    assign carrier_reset_n = (up_r > delay) && carrier_reset_out_n && !hold_reset;
endmodule
`default_nettype wire

// file: test_module_carrier_power_handshake.sv
// Self-checking bench for the power handshake block.
`timescale 1ns/1ps
`default_nettype none
module test_module_carrier_power_handshake
    import mch_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, input_supply_fault_n, module_power_ready, sd_boot_strap_n;
    logic lid_closed_n, doze_request_n, battery_depleted_n, sideband_wake_n, hold;
    logic charger_input_present_n, carrier_reset_n, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, module_supplies_enable;
    logic downstream_power_enable, carrier_reset_out_n, boot_release, boot_from_sd;
    logic standby_indicator_n, panel0_supply_on, panel0_backlight_on;
    logic panel0_brightness_pulse;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  dly;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          n_fail = 0;
    int          checks = 0;
    wire  [6:0]  pins = {panel0_backlight_on, panel0_supply_on, standby_indicator_n,
        boot_release, carrier_reset_out_n, downstream_power_enable, module_supplies_enable};

    mch_top #(.DEBOUNCE_CYCLES(32'h0000_0004), .SETTLE_CYCLES(32'h0000_0004)) i_dut (.*);
    mch_carrier_model i_car (.*, .hold_reset(hold), .delay(dly));

    // Free-running 200 MHz clock.
    always #2.5 aclk = ~aclk;

    task automatic give_verdict;
        $display("counts: checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A used-up wait bound counts as a failure and ends the run.
    task automatic tmo(input int n);
        if (n >= 4000)
        begin
            cmp("wait", 34'h0, 34'h1);
            give_verdict();
        end
    endtask

    task automatic wt(input int k, input logic v);
        int n;
        n = 0;
        while (pins[k] !== v && n < 4000)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 4000);
        tmo(n);
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 4000);
        tmo(n);
    endtask

    // Pairs each bus answer with the oldest expectation; ready stays high.
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    initial
    begin
        int cnt;
        int duty;
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hold} = '0;
        {input_supply_fault_n, module_power_ready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_bready, s_axi_rready, sd_boot_strap_n, lid_closed_n} = '1;
        {doze_request_n, battery_depleted_n, sideband_wake_n, charger_input_present_n} = '1;
        s_axi_wstrb = 4'hf;
        s_axi_wdata = 32'h0000_0000;
        void'($urandom(32'h7764a177));
        dly = 8'($urandom_range(40, 0));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(12'h000, 34'h0_0000_0001);
        rd(12'h008, 34'h0_0000_0080);
        rd(12'h100, 34'h2_0000_0000);
        wr(12'h100, 32'h0000_0005, 2'b10);
        wr(12'h004, 32'h0000_ffff, 2'b00);
        cmp("pins", 34'h10, {27'h0, pins});
        $display("test reset and registers done");
        module_power_ready <= 1'b1;
        sd_boot_strap_n <= 1'b0;
        input_supply_fault_n <= 1'b1;
        wt(1, 1'b1);
        cmp("pins", 34'h13, {27'h0, pins});
        wt(2, 1'b1);
        cmp("pins", 34'h17, {27'h0, pins});
        wt(3, 1'b1);
        cmp("sd", 34'h1, {33'h0, boot_from_sd});
        $display("test power-up done");
        duty = $urandom_range(255, 1);
        cnt = 0;
        wr(12'h008, 32'(duty), 2'b00);
        wr(12'h000, 32'h0000_000d, 2'b00);
        wt(6, 1'b1);
        repeat (256 * 49)
        begin
            @(posedge aclk);
            cnt += int'(panel0_brightness_pulse);
        end
        cmp("pulse", 34'(duty * 49), 34'(cnt));
        wr(12'h000, 32'h0000_0005, 2'b00);
        wt(6, 1'b0);
        cmp("pins", 34'h3f, {27'h0, pins});
        $display("test panel done");
        battery_depleted_n <= 1'b0;
        charger_input_present_n <= 1'b0;
        doze_request_n <= 1'b0;
        repeat (2) @(posedge aclk);
        doze_request_n <= 1'b1;
        repeat (20) @(posedge aclk);
        cmp("stby", 34'h1, {33'h0, standby_indicator_n});
        rd(12'h004, 34'h0_0000_062b);
        for (int k = 0; k < 3; k++)
        begin
            doze_request_n <= (k != 0);
            lid_closed_n <= (k != 1);
            if (k == 2)
                wr(12'h000, 32'h0000_0007, 2'b00);
            wt(4, 1'b0);
            doze_request_n <= 1'b1;
            lid_closed_n <= 1'b1;
            if (k == 2)
                wr(12'h000, 32'h0000_0005, 2'b00);
            wt(4, 1'b1);
        end
        rd(12'h014, 34'h0_0000_0006);
        wr(12'h014, 32'h0000_0006, 2'b00);
        wr(12'h000, 32'h0000_0007, 2'b00);
        wt(4, 1'b0);
        sideband_wake_n <= 1'b0;
        wt(4, 1'b1);
        wr(12'h000, 32'h0000_0005, 2'b00);
        sideband_wake_n <= 1'b1;
        rd(12'h014, 34'h0_0000_0001);
        $display("test standby done");
        hold <= 1'b1;
        wt(3, 1'b0);
        hold <= 1'b0;
        wt(3, 1'b1);
        input_supply_fault_n <= 1'b0;
        wt(1, 1'b0);
        cmp("pins", 34'h10, {27'h0, pins});
        sd_boot_strap_n <= 1'b1;
        dly <= 8'($urandom_range(40, 0));
        input_supply_fault_n <= 1'b1;
        wt(3, 1'b1);
        cmp("sd", 34'h0, {33'h0, boot_from_sd});
        $display("test carrier reset and fault done");
        give_verdict();
    end
endmodule
`default_nettype wire
